// file: hw/uerb_endpoint_map.sv
/*
 * Per-endpoint control of a USB device: handshake selection, data toggles
 * with automatic flipping, transmit lengths, enables and buffer mapping.
 * Assumes a protocol engine that asks per transaction and reports success,
 * and firmware on a plain address/strobe register port.
 */
`timescale 1ns/1ps

// What this block does
// - Auto-toggle on endpoints 1-3 flips the toggle after each successful transfer.
// - Receive select answers SETUP/OUT with ACK, nothing, NAK or STALL.
// - Transmit select answers IN with data-ACK, data-no-handshake, NAK or STALL.
// - Eight-bit transmit count per endpoint; endpoint 2 count resets to zero.
// - Mode 1/4 bits 7,6,4: endpoint 1 receive, transmit, double buffer.
// - Mode 1/4 bits 3,2: endpoint 4 receive, transmit; bits 5,1,0 read zero.
// - Endpoint 0 shares one buffer; endpoint 4 receive +64, transmit +128.
// - Single endpoint 4 direction uses the buffer right after endpoint 0.
// - Mode 2/3 bits 7,6,4: endpoint 3 receive, transmit, double buffer.
// - Mode 2/3 bits 3,2,0: endpoint 2 receive, transmit, double buffer.
// - Endpoint 1-3 with both enables clear is disabled and uses no buffer.
// - Single buffer: one direction at base; both: receive base, transmit +64.
// - Double buffer picks first or second buffer by the direction's toggle.
// - Both directions doubled: receive at +0/+64, transmit at +128/+192.
// - Base address is low byte plus two low bits of the high byte.
// - Receive toggle gives expected data PID; transmit toggle selects DATA0/1.
// - Pause with transfer-done pending answers every transaction with NAK.
module uerb_endpoint_map (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic transfer_done_flag,
    input wire logic xact_req,
    input wire logic [2:0] xact_ep,
    input wire logic xact_in,
    input wire logic done_pulse,
    input wire logic [2:0] done_ep,
    input wire logic done_in,
    output logic resp_valid,
    output logic [1:0] resp_code,
    output logic resp_enabled,
    output logic resp_toggle,
    output logic [9:0] resp_buf_addr,
    output logic [7:0] resp_tx_len
);

    // ********************************************
    // Register storage
    // ********************************************
    logic [7:0] ctrl_reg [uerb_pkg::NUM_EP];
    logic [7:0] tlen_reg [uerb_pkg::NUM_EP];
    logic [7:0] base_low_reg [uerb_pkg::NUM_BASE];
    logic [1:0] base_high_reg [uerb_pkg::NUM_BASE];
    logic [7:0] mode_1_4_reg;
    logic [7:0] mode_2_3_reg;
    logic pause_reg;

    // ********************************************
    // Helper functions
    // ********************************************
    function automatic logic [9:0] base_of(input logic [7:0] lo,
                                           input logic [1:0] hi);
        base_of = {hi, lo};
    endfunction : base_of

    // Register address match: block start plus index times stride
    function automatic logic addr_hit(input logic [7:0] addr,
                                      input logic [7:0] start,
                                      input int idx,
                                      input int stride);
        addr_hit = (addr == 8'(start + stride * idx));
    endfunction : addr_hit

    // Busy answer forced while a transfer-done flag waits with pause set
    function automatic logic forced_busy(input logic pause,
                                         input logic done);
        forced_busy = pause & done;
    endfunction : forced_busy

    // Enables and double-buffer flag of an endpoint as {rx, tx, dbuf}
    function automatic logic [2:0] ep_mode(input logic [2:0] ep,
                                           input logic [7:0] m14,
                                           input logic [7:0] m23);
        unique case (ep)
            3'd1: ep_mode = {m14[uerb_pkg::MODE_HI_RX_EN], m14[uerb_pkg::MODE_HI_TX_EN],
                             m14[uerb_pkg::MODE_HI_DBUF]};
            3'd2: ep_mode = {m23[uerb_pkg::MODE_LO_RX_EN], m23[uerb_pkg::MODE_LO_TX_EN],
                             m23[uerb_pkg::MODE_LO_DBUF]};
            3'd3: ep_mode = {m23[uerb_pkg::MODE_HI_RX_EN], m23[uerb_pkg::MODE_HI_TX_EN],
                             m23[uerb_pkg::MODE_HI_DBUF]};
            3'd4: ep_mode = {m14[uerb_pkg::MODE_LO_RX_EN], m14[uerb_pkg::MODE_LO_TX_EN],
                             1'b0};
            3'd0: ep_mode = 3'b110;
            default: ep_mode = 3'b000;
        endcase
    endfunction : ep_mode

    // Buffer offset from the endpoint base for one direction
    function automatic logic [9:0] buf_offset(input logic [2:0] ep,
                                              input logic [2:0] mode,
                                              input logic dir_in,
                                              input logic tog);
        logic both;
        logic [9:0] ofs;
        both = mode[2] & mode[1];
        ofs = 10'h000;
        if (ep == 3'd0) begin
            ofs = 10'h000;
        end else if (ep == 3'd4) begin
            if (both && dir_in) begin
                ofs = 10'(uerb_pkg::BUF_STEP * 2);
            end else begin
                ofs = uerb_pkg::BUF_STEP;
            end
        end else if (!mode[0]) begin
            ofs = (both && dir_in) ? uerb_pkg::BUF_STEP : 10'h000;
        end else begin
            ofs = tog ? uerb_pkg::BUF_STEP : 10'h000;
            if (both && dir_in) begin
                ofs = 10'(ofs + uerb_pkg::BUF_STEP * 2);
            end
        end
        buf_offset = ofs;
    endfunction : buf_offset

    // ********************************************
    // Endpoint control registers and auto-toggle
    // ********************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int i = 0; i < uerb_pkg::NUM_EP; i++) begin
                ctrl_reg[i] <= uerb_pkg::RST_BYTE;
            end
        end else begin
            for (int i = 0; i < uerb_pkg::NUM_EP; i++) begin
                if (reg_wr && addr_hit(reg_addr, uerb_pkg::OFS_CTRL_BASE, i, 1)) begin
                    ctrl_reg[i] <= reg_wdata & uerb_pkg::CTRL_MASK;
                end else if (done_pulse && done_ep == 3'(i) && i >= 1 && i <= 3 &&
                             ctrl_reg[i][uerb_pkg::CTRL_AUTO_TOG]) begin
                    if (done_in) begin
                        ctrl_reg[i][uerb_pkg::CTRL_TX_TOG] <=
                            ~ctrl_reg[i][uerb_pkg::CTRL_TX_TOG];
                    end else begin
                        ctrl_reg[i][uerb_pkg::CTRL_RX_TOG] <=
                            ~ctrl_reg[i][uerb_pkg::CTRL_RX_TOG];
                    end
                end
            end
        end
    end

    // ********************************************
    // Transmit lengths
    // ********************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int i = 0; i < uerb_pkg::NUM_EP; i++) begin
                tlen_reg[i] <= uerb_pkg::RST_BYTE;
            end
        end else begin
            for (int i = 0; i < uerb_pkg::NUM_EP; i++) begin
                if (reg_wr && addr_hit(reg_addr, uerb_pkg::OFS_TLEN_BASE, i, 1)) begin
                    tlen_reg[i] <= reg_wdata;
                end
            end
        end
    end

    // ********************************************
    // Mode, base address and system control
    // ********************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mode_1_4_reg <= uerb_pkg::RST_BYTE;
            mode_2_3_reg <= uerb_pkg::RST_BYTE;
        end else if (reg_wr) begin
            if (reg_addr == uerb_pkg::OFS_MODE_1_4) begin
                mode_1_4_reg <= reg_wdata & uerb_pkg::MODE_1_4_MASK;
            end
            if (reg_addr == uerb_pkg::OFS_MODE_2_3) begin
                mode_2_3_reg <= reg_wdata & uerb_pkg::MODE_2_3_MASK;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pause_reg <= 1'b0;
        end else if (reg_wr && reg_addr == uerb_pkg::OFS_SYS_CTRL) begin
            pause_reg <= reg_wdata[uerb_pkg::SYS_PAUSE];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int i = 0; i < uerb_pkg::NUM_BASE; i++) begin
                base_low_reg[i] <= uerb_pkg::RST_BYTE;
            end
        end else begin
            for (int i = 0; i < uerb_pkg::NUM_BASE; i++) begin
                if (reg_wr && addr_hit(reg_addr, uerb_pkg::OFS_BASE_LOW0, i, 2)) begin
                    base_low_reg[i] <= reg_wdata;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            for (int i = 0; i < uerb_pkg::NUM_BASE; i++) begin
                base_high_reg[i] <= 2'b00;
            end
        end else begin
            for (int i = 0; i < uerb_pkg::NUM_BASE; i++) begin
                if (reg_wr && addr_hit(reg_addr, uerb_pkg::OFS_BASE_LOW0 + 8'h01, i, 2)) begin
                    base_high_reg[i] <= reg_wdata[1:0];
                end
            end
        end
    end

    // ********************************************
    // Register read port
    // ********************************************
    logic [7:0] read_value;

    always_comb begin
        read_value = 8'h00;
        for (int i = 0; i < uerb_pkg::NUM_EP; i++) begin
            if (addr_hit(reg_addr, uerb_pkg::OFS_CTRL_BASE, i, 1)) begin
                read_value = ctrl_reg[i];
            end
            if (addr_hit(reg_addr, uerb_pkg::OFS_TLEN_BASE, i, 1)) begin
                read_value = tlen_reg[i];
            end
        end
        for (int i = 0; i < uerb_pkg::NUM_BASE; i++) begin
            if (addr_hit(reg_addr, uerb_pkg::OFS_BASE_LOW0, i, 2)) begin
                read_value = base_low_reg[i];
            end
            if (addr_hit(reg_addr, uerb_pkg::OFS_BASE_LOW0 + 8'h01, i, 2)) begin
                read_value = {6'h00, base_high_reg[i]};
            end
        end
        if (reg_addr == uerb_pkg::OFS_MODE_1_4) begin
            read_value = mode_1_4_reg;
        end
        if (reg_addr == uerb_pkg::OFS_MODE_2_3) begin
            read_value = mode_2_3_reg;
        end
        if (reg_addr == uerb_pkg::OFS_SYS_CTRL) begin
            read_value = {7'h00, pause_reg};
        end
        if (reg_addr == uerb_pkg::OFS_STATUS) begin
            read_value = {6'h00, forced_busy(pause_reg, transfer_done_flag),
                          transfer_done_flag};
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? read_value : 8'h00;
        end
    end

    // ********************************************
    // Transaction answer
    // ********************************************
    logic [2:0] req_mode;
    logic [7:0] req_ctrl;
    logic [1:0] req_code;
    logic req_enabled;
    logic req_toggle;
    logic [9:0] req_base;
    logic [7:0] req_len;

    always_comb begin
        req_mode = ep_mode(xact_ep, mode_1_4_reg, mode_2_3_reg);
        req_ctrl = 8'h00;
        req_len = 8'h00;
        req_base = 10'h000;
        if (xact_ep < 3'(uerb_pkg::NUM_EP)) begin
            req_ctrl = ctrl_reg[xact_ep];
            req_len = tlen_reg[xact_ep];
        end
        if (xact_ep == 3'd0 || xact_ep == 3'd4) begin
            req_base = base_of(base_low_reg[0], base_high_reg[0]);
        end else if (xact_ep <= 3'd3) begin
            req_base = base_of(base_low_reg[xact_ep[1:0]], base_high_reg[xact_ep[1:0]]);
        end
        req_enabled = xact_in ? req_mode[1] : req_mode[2];
        req_toggle = xact_in ? req_ctrl[uerb_pkg::CTRL_TX_TOG]
                             : req_ctrl[uerb_pkg::CTRL_RX_TOG];
        req_code = xact_in ? req_ctrl[1:0] : req_ctrl[3:2];
        if (forced_busy(pause_reg, transfer_done_flag)) begin
            req_code = uerb_pkg::RESP_NAK;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            resp_valid <= 1'b0;
        end else begin
            resp_valid <= xact_req;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            resp_code <= uerb_pkg::RESP_NAK;
        end else if (xact_req) begin
            resp_code <= req_code;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            resp_enabled <= 1'b0;
            resp_toggle <= 1'b0;
        end else if (xact_req) begin
            resp_enabled <= req_enabled;
            resp_toggle <= req_toggle;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            resp_buf_addr <= 10'h000;
        end else if (xact_req) begin
            resp_buf_addr <= req_enabled ?
                10'(req_base + buf_offset(xact_ep, req_mode, xact_in, req_toggle)) :
                10'h000;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            resp_tx_len <= 8'h00;
        end else if (xact_req) begin
            resp_tx_len <= xact_in ? req_len : 8'h00;
        end
    end

endmodule : uerb_endpoint_map

// file: hw/uerb_pkg.sv
/*
 * Constants shared by the endpoint response and buffer map block:
 * register offsets, field positions, reset values, response codes.
 * Assumes an 8-bit register port and a 10-bit buffer memory address.
 */
package uerb_pkg;

    // ********************************************
    // Register offsets
    // ********************************************
    localparam logic [7:0] OFS_CTRL_BASE = 8'h00;
    localparam logic [7:0] OFS_TLEN_BASE = 8'h08;
    localparam logic [7:0] OFS_MODE_1_4 = 8'h10;
    localparam logic [7:0] OFS_MODE_2_3 = 8'h11;
    localparam logic [7:0] OFS_BASE_LOW0 = 8'h18;
    localparam logic [7:0] OFS_SYS_CTRL = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h21;

    // ********************************************
    // Field positions
    // ********************************************
    localparam int CTRL_RX_TOG = 7;
    localparam int CTRL_TX_TOG = 6;
    localparam int CTRL_AUTO_TOG = 4;
    localparam int MODE_HI_RX_EN = 7;
    localparam int MODE_HI_TX_EN = 6;
    localparam int MODE_HI_DBUF = 4;
    localparam int MODE_LO_RX_EN = 3;
    localparam int MODE_LO_TX_EN = 2;
    localparam int MODE_LO_DBUF = 0;
    localparam int SYS_PAUSE = 0;

    // ********************************************
    // Writable masks and reset values
    // ********************************************
    localparam logic [7:0] CTRL_MASK = 8'hDF;
    localparam logic [7:0] MODE_1_4_MASK = 8'hDC;
    localparam logic [7:0] MODE_2_3_MASK = 8'hDD;
    localparam logic [7:0] BASE_HIGH_MASK = 8'h03;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [9:0] BUF_STEP = 10'h040;

    // ********************************************
    // Handshake codes
    // ********************************************
    typedef enum logic [1:0] {
        RESP_ACK = 2'b00,
        RESP_NONE = 2'b01,
        RESP_NAK = 2'b10,
        RESP_STALL = 2'b11
    } uerb_resp_t;

    localparam int NUM_EP = 5;
    localparam int NUM_BASE = 4;

endpackage : uerb_pkg

// file: bench/uerb_endpoint_map_props.sv
/* Port checker for the endpoint map block.
   Sees only the top ports; bound into every instance below. */
`timescale 1ns/1ps
module uerb_endpoint_map_props (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic transfer_done_flag,
    input wire logic xact_req,
    input wire logic [2:0] xact_ep,
    input wire logic xact_in,
    input wire logic done_pulse,
    input wire logic [2:0] done_ep,
    input wire logic done_in,
    input wire logic resp_valid,
    input wire logic [1:0] resp_code,
    input wire logic resp_enabled,
    input wire logic resp_toggle,
    input wire logic [9:0] resp_buf_addr,
    input wire logic [7:0] resp_tx_len
);
    logic pause_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Pause bit as firmware last wrote it
    always_ff @(posedge mclk) begin
        if (sys_rst)
            pause_q <= 1'h0;
        else if (reg_wr && reg_addr == uerb_pkg::OFS_SYS_CTRL)
            pause_q <= reg_wdata[uerb_pkg::SYS_PAUSE];
    end
    property p_valid; xact_req |=> resp_valid; endproperty
    a_valid: assert property (p_valid) else $error("no answer after request");
    property p_cause; resp_valid |-> $past(xact_req); endproperty
    a_cause: assert property (p_cause) else $error("answer without request");
    property p_hold;
        !xact_req |=> $stable({resp_code, resp_buf_addr, resp_tx_len, resp_toggle});
    endproperty
    a_hold: assert property (p_hold) else $error("result changed without request");
    property p_rdzero; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rdzero: assert property (p_rdzero) else $error("read data without strobe");
    property p_outlen; xact_req && !xact_in |=> resp_tx_len == 8'h00; endproperty
    a_outlen: assert property (p_outlen) else $error("length on receive");
    property p_ep0; xact_req && xact_ep == 3'h0 |=> resp_enabled; endproperty
    a_ep0: assert property (p_ep0) else $error("endpoint 0 not enabled");
    property p_dis; resp_valid && !resp_enabled |-> resp_buf_addr == 10'h000; endproperty
    a_dis: assert property (p_dis) else $error("disabled endpoint uses buffer");
    property p_pause;
        xact_req && pause_q && transfer_done_flag |=> resp_code == uerb_pkg::RESP_NAK;
    endproperty
    a_pause: assert property (p_pause) else $error("pause did not force busy");
    c_in: cover property (xact_req && xact_in);
    c_done: cover property (done_pulse);
    c_pause: cover property (xact_req && pause_q && transfer_done_flag);
endmodule : uerb_endpoint_map_props

bind uerb_endpoint_map uerb_endpoint_map_props chk_u (
    .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .transfer_done_flag(transfer_done_flag), .xact_req(xact_req), .xact_ep(xact_ep),
    .xact_in(xact_in), .done_pulse(done_pulse), .done_ep(done_ep), .done_in(done_in),
    .resp_valid(resp_valid), .resp_code(resp_code), .resp_enabled(resp_enabled),
    .resp_toggle(resp_toggle), .resp_buf_addr(resp_buf_addr), .resp_tx_len(resp_tx_len)
);

// file: bench/uerb_token_host.sv
/* Protocol engine stand-in: token requests and done pulses on command.
   Assumes the bench calls its tasks; mclk is the block clock. */
`timescale 1ns/1ps
module uerb_token_host (
    input wire logic mclk,
    output logic xact_req,
    output logic [2:0] xact_ep,
    output logic xact_in,
    output logic done_pulse,
    output logic [2:0] done_ep,
    output logic done_in
);
    initial begin
        xact_req = 1'h0;
        xact_ep = 3'h7;
        xact_in = 1'h0;
        done_pulse = 1'h0;
        done_ep = 3'h7;
        done_in = 1'h0;
    end
    // One-cycle request; qualifiers inverted once released
    task automatic token(input logic [2:0] ep, input logic dir);
        @(posedge mclk);
        xact_req <= 1'h1;
        xact_ep <= ep;
        xact_in <= dir;
        @(posedge mclk);
        xact_req <= 1'h0;
        xact_ep <= ~ep;
        xact_in <= ~dir;
    endtask : token
    task automatic done(input logic [2:0] ep, input logic dir);
        @(posedge mclk);
        done_pulse <= 1'h1;
        done_ep <= ep;
        done_in <= dir;
        @(posedge mclk);
        done_pulse <= 1'h0;
        done_ep <= ~ep;
        done_in <= ~dir;
    endtask : done
endmodule : uerb_token_host

// file: bench/tb_usb_endpoint_response_buffer_map.sv
/* Self-checking bench for the endpoint map block.
   Assumes the package offsets and the partner model beside it. */
`timescale 1ns/1ps
module tb_usb_endpoint_response_buffer_map;
    logic mclk, sys_rst, reg_wr, reg_rd, transfer_done_flag;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, resp_tx_len;
    logic xact_req, xact_in, done_pulse, done_in, resp_valid, resp_enabled, resp_toggle;
    logic [2:0] xact_ep, done_ep;
    logic [1:0] resp_code;
    logic [9:0] resp_buf_addr;
    logic [7:0] ctl[5], tl[5], bl[4], bh[4], m14, m23;
    int bad_count, checks_done, cycles;

    uerb_endpoint_map dut_u (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .transfer_done_flag(transfer_done_flag), .xact_req(xact_req), .xact_ep(xact_ep),
        .xact_in(xact_in), .done_pulse(done_pulse), .done_ep(done_ep), .done_in(done_in),
        .resp_valid(resp_valid), .resp_code(resp_code), .resp_enabled(resp_enabled),
        .resp_toggle(resp_toggle), .resp_buf_addr(resp_buf_addr), .resp_tx_len(resp_tx_len));
    uerb_token_host host_u (.mclk(mclk), .xact_req(xact_req), .xact_ep(xact_ep),
        .xact_in(xact_in), .done_pulse(done_pulse), .done_ep(done_ep), .done_in(done_in));

    // ****************
    // Tasks and model
    // ****************
    task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1;
        d = reg_rdata;
    endtask : rd
    // Expected {enabled, buffer start} for one request
    function automatic logic [10:0] exp_map(input int ep, input logic dir);
        logic rx, tx, db, tg, both;
        logic [9:0] b, off;
        b = (ep == 4) ? {bh[0][1:0], bl[0]} : {bh[ep][1:0], bl[ep]};
        tg = dir ? ctl[ep][6] : ctl[ep][7];
        rx = ep == 1 ? m14[7] : ep == 2 ? m23[3] : ep == 3 ? m23[7] : m14[3];
        tx = ep == 1 ? m14[6] : ep == 2 ? m23[2] : ep == 3 ? m23[6] : m14[2];
        db = ep == 1 ? m14[4] : ep == 2 ? m23[0] : ep == 3 ? m23[4] : 1'h0;
        both = rx && tx;
        if (ep == 0)
            return {1'h1, b};
        if (!(dir ? tx : rx))
            return 11'h000;
        if (ep == 4)
            off = (both && dir) ? 10'h080 : 10'h040;
        else if (db)
            off = ((both && dir) ? 10'h080 : 10'h000) + (tg ? 10'h040 : 10'h000);
        else
            off = (both && dir) ? 10'h040 : 10'h000;
        return {1'h1, b + off};
    endfunction : exp_map
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            give_verdict();
        end
    end

    // ****************
    // Main sequence
    // ****************
    initial begin
        logic [7:0] d;
        static logic [7:0] ra[5] = '{8'h10, 8'h11, 8'h19, 8'h01, 8'h30};
        static logic [7:0] rm[5] = '{8'hDC, 8'hDD, 8'h03, 8'hDF, 8'h00};
        logic dir, pz;
        int ep, bi;
        sys_rst = 1'h1;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        transfer_done_flag = 1'h0;
        void'($urandom(27612));
        repeat (2) @(posedge mclk);
        sys_rst <= 1'h0;
        for (int i = 0; i < 5; i++) begin
            rd(uerb_pkg::OFS_CTRL_BASE + 8'(i), d);
            chk(11'(d), 11'h000);
            rd(uerb_pkg::OFS_TLEN_BASE + 8'(i), d);
            chk(11'(d), 11'h000);
            wr(ra[i], 8'hFF);
            rd(ra[i], d);
            chk(11'(d), 11'(rm[i]));
        end
        $display("reset and reserved test done");
        for (int n = 0; n < 300; n++) begin
            ep = $urandom_range(4);
            bi = (ep == 4) ? 0 : ep;
            dir = 1'($urandom);
            pz = 1'($urandom);
            ctl[ep] = 8'($urandom) & 8'hCF;
            tl[ep] = 8'($urandom);
            m14 = 8'($urandom) & 8'hDC;
            m23 = 8'($urandom) & 8'hDD;
            bl[bi] = 8'($urandom);
            bh[bi] = 8'($urandom);
            wr(uerb_pkg::OFS_CTRL_BASE + 8'(ep), ctl[ep]);
            wr(uerb_pkg::OFS_TLEN_BASE + 8'(ep), tl[ep]);
            wr(uerb_pkg::OFS_MODE_1_4, m14);
            wr(uerb_pkg::OFS_MODE_2_3, m23);
            wr(uerb_pkg::OFS_BASE_LOW0 + 8'(2 * bi), bl[bi]);
            wr(uerb_pkg::OFS_BASE_LOW0 + 8'(2 * bi + 1), bh[bi]);
            wr(uerb_pkg::OFS_SYS_CTRL, {7'h00, pz});
            transfer_done_flag <= 1'($urandom);
            host_u.token(3'(ep), dir);
            #1;
            chk(11'(resp_valid), 11'h001);
            chk({resp_enabled, resp_buf_addr}, exp_map(ep, dir));
            chk(11'(resp_toggle), 11'(dir ? ctl[ep][6] : ctl[ep][7]));
            chk(11'(resp_tx_len), dir ? 11'(tl[ep]) : 11'h000);
            chk(11'(resp_code), (pz && transfer_done_flag) ? 11'h002 :
                11'(dir ? ctl[ep][1:0] : ctl[ep][3:2]));
            rd(uerb_pkg::OFS_STATUS, d);
            chk(11'(d), 11'({pz & transfer_done_flag, transfer_done_flag}));
            rd(uerb_pkg::OFS_SYS_CTRL, d);
            chk(11'(d), 11'(pz));
        end
        for (int e = 5; e < 8; e++) begin
            host_u.token(3'(e), 1'h1);
            #1;
            chk({resp_enabled, resp_buf_addr}, 11'h000);
            chk(11'(resp_tx_len), 11'h000);
        end
        $display("random map and response test done");
        for (int k = 0; k < 10; k++) begin
            ep = k / 2;
            dir = 1'(k % 2);
            wr(uerb_pkg::OFS_CTRL_BASE + 8'(ep), 8'h10);
            host_u.done(3'(ep), dir);
            rd(uerb_pkg::OFS_CTRL_BASE + 8'(ep), d);
            chk(11'(d), (ep >= 1 && ep <= 3) ? (dir ? 11'h050 : 11'h090) : 11'h010);
        end
        $display("auto toggle test done");
        give_verdict();
    end
endmodule : tb_usb_endpoint_response_buffer_map
